/* File: tcc_pkg.sv */
// Purpose: constants and types for the 8-bit timer/counter with compare
// Assumes: one 100 MHz system clock, synchronous active-high reset
// Notes: control and status bits are plain ports, no register bus
// Operation
// R1: zero count raises bottom indication
// R2: count 255 is the maximum
// R3: top is maximum or compare A by mode
// R4: counter and compare registers are 8 bits
// R5: flags in one register, masked individually
// R6: tick from prescaled clock or external edge
// R7: clock select zero stops the counter
// R8: each tick clears, increments or decrements
// R9: software counter write beats clear or count
// R10: 3-bit mode split over two controls
// R11: overflow flag set per mode, requests interrupt
// R12: continuous compare against both registers
// R13: match sets compare flag next tick
// R14: flag cleared by service or writing one
// R15: compare double buffered in PWM modes only
// R16: buffer copied to active at top/bottom
// R17: writes reach buffer or active register
// R18: force strobe updates output, no flag/clear
// R19: counter write blocks next tick match
// R20: software avoids writing counter equal compare
// R21: output state kept across mode changes
// R22: output action field takes effect immediately
// R23: clock select encodings 1..7 as listed
// R24: modes 0 normal, 2 clear, 3/7 fast PWM
// R25: reset clears output compare state
// R26: counter, compares, buffers, flags reset zero
package tcc_pkg;
  localparam logic [7:0] TCC_BOTTOM   = 8'h00;
  localparam logic [7:0] TCC_MAX      = 8'hff;
  localparam logic [7:0] TCC_RST_BYTE = 8'h00;
  localparam logic [2:0] CS_STOP      = 3'h0;
  localparam logic [2:0] CS_DIV1      = 3'h1;
  localparam logic [2:0] CS_DIV8      = 3'h2;
  localparam logic [2:0] CS_DIV64     = 3'h3;
  localparam logic [2:0] CS_DIV256    = 3'h4;
  localparam logic [2:0] CS_DIV1024   = 3'h5;
  localparam logic [2:0] CS_EXT_FALL  = 3'h6;
  localparam logic [2:0] CS_EXT_RISE  = 3'h7;
  localparam logic [2:0] WM_NORMAL    = 3'h0;
  localparam logic [2:0] WM_CLEAR     = 3'h2;
  localparam logic [2:0] WM_FAST_MAX  = 3'h3;
  localparam logic [2:0] WM_FAST_A    = 3'h7;
  localparam logic [1:0] ACT_NONE     = 2'h0;
  localparam logic [1:0] ACT_TOGGLE   = 2'h1;
  localparam logic [1:0] ACT_CLEAR    = 2'h2;
  localparam logic [1:0] ACT_SET      = 2'h3;
  localparam int         PRE_W        = 10;
  localparam int         FLAG_OVF     = 0;
  localparam int         FLAG_CMPA    = 1;
  localparam int         FLAG_CMPB    = 2;
endpackage

/* File: tcc_cmp_if.sv */
// Purpose: carries counter state from counter to compare channels
// Assumes: all signals on the system clock
// Notes: one instance per compare channel
interface tcc_cmp_if;
  import tcc_pkg::*;
  logic [7:0] count;
  logic       tick;
  logic       blocked;
  logic       pwm;
  logic       at_top;
  logic       at_bottom;
  logic       fast;
  logic       match;
  logic [7:0] active;
  modport ctr (output count, tick, blocked, pwm, at_top, at_bottom, fast,
               input match, active);
  modport chn (input count, tick, blocked, pwm, at_top, at_bottom, fast,
               output match, active);
endinterface

/* File: tcc_compare_ch.sv */
// Purpose: one output compare channel
// Assumes: wr strobes are one-cycle pulses from same clock
// Notes: wave state is never touched by mode changes
module tcc_compare_ch (
  input  wire logic       clock,
  input  wire logic       srst,
  tcc_cmp_if.chn          cb,
  input  wire logic       cmp_wr,
  input  wire logic [7:0] cmp_wdata,
  input  wire logic [1:0] action,
  input  wire logic       force_strobe,
  output logic [7:0]      cmp_rdata,
  output logic            wave_r,
  output logic            flag_set
);
  import tcc_pkg::*;
  logic [7:0] active_r;
  logic [7:0] buf_r;
  logic       wave_nxt;
  wire        do_match;
  wire        is_match;
  wire        load_buf;

  function automatic logic apply(input logic [1:0] a, input logic w);
    unique case (a)
      ACT_NONE:   apply = w;
      ACT_TOGGLE: apply = ~w;
      ACT_CLEAR:  apply = 1'b0;
      ACT_SET:    apply = 1'b1;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  assign is_match  = (cb.count == active_r);                     // R12
  assign cb.match  = is_match;
  assign cb.active = active_r;
  // match lands on the tick after detection unless a counter write blocks
  assign do_match  = cb.tick & is_match & ~cb.blocked;           // R13 R19
  assign flag_set  = do_match;
  assign load_buf  = cb.pwm & cb.tick & (cb.at_top | cb.at_bottom); // R16
  assign cmp_rdata = cb.pwm ? buf_r : active_r;                  // R17

  always_comb begin
    wave_nxt = wave_r;
    if (force_strobe && !cb.pwm) begin
      wave_nxt = apply(action, wave_r);                          // R18 R22
    end else if (do_match) begin
      if (cb.fast) begin
        // simplified pwm: clear or set on match per high action bit
        wave_nxt = action[1] ? action[0] : wave_r;
      end else begin
        wave_nxt = apply(action, wave_r);                        // R22
      end
    end else if (cb.fast && cb.tick && cb.at_bottom && action[1]) begin
      wave_nxt = ~action[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock) begin
    if (srst) begin
      active_r <= TCC_RST_BYTE;                                  // R26
      buf_r    <= TCC_RST_BYTE;
      wave_r   <= 1'b0;                                          // R25
    end else begin
      if (cmp_wr && !cb.pwm) active_r <= cmp_wdata;              // R15 R17
      else if (load_buf) active_r <= buf_r;                      // R16
      if (cmp_wr) buf_r <= cmp_wdata;                            // R15
      wave_r <= wave_nxt;                                        // R21
    end
  end
endmodule

/* File: tcc_timer8.sv */
// Purpose: 8-bit timer/counter with two compare channels
// Assumes: software strobes are one-cycle pulses on the system clock
// Notes: prescaler is local and free running; ext input is a pin
module tcc_timer8 (
  input  wire logic              clock,
  input  wire logic              srst,
  input  wire logic              external_count_input,
  input  wire logic [2:0]        clock_select_field,
  input  wire logic              waveform_mode_bit0,
  input  wire logic              waveform_mode_bit1,
  input  wire logic              waveform_mode_bit2,
  input  wire logic              counter_wr,
  input  wire logic [7:0]        counter_wdata,
  input  wire logic              compare_a_wr,
  input  wire logic [7:0]        compare_a_wdata,
  input  wire logic              compare_b_wr,
  input  wire logic [7:0]        compare_b_wdata,
  input  wire logic [1:0]        output_action_a,
  input  wire logic [1:0]        output_action_b,
  input  wire logic              force_compare_strobe_a,
  input  wire logic              force_compare_strobe_b,
  input  wire logic [2:0]        timer_irq_mask_reg,
  input  wire logic              flag_wr,
  input  wire logic [2:0]        flag_wdata,
  input  wire logic [2:0]        irq_ack,
  output logic [7:0]             counter_value,
  output logic [7:0]             compare_value_a,
  output logic [7:0]             compare_value_b,
  output logic [2:0]             timer_flag_reg,
  output logic [2:0]             irq_req,
  output logic                   bottom,
  output logic                   waveform_out_a,
  output logic                   waveform_out_b
);
  import tcc_pkg::*;

  tcc_cmp_if ca ();
  tcc_cmp_if cb ();

  logic [7:0]       cnt_r;
  logic [7:0]       cnt_nxt;
  logic [PRE_W-1:0] pre_r;
  logic [2:0]       ext_sync_r;
  logic             blk_r;
  logic [2:0]       flag_r;
  logic [2:0]       flag_nxt;
  logic [2:0]       irq_r;
  logic             bottom_r;
  logic [7:0]       cmpa_rd_r;
  logic [7:0]       cmpb_rd_r;
  logic [7:0]       cmpa_rd;
  logic [7:0]       cmpb_rd;
  logic             set_a;
  logic             set_b;
  logic             wave_a;
  logic             wave_b;
  logic [2:0]       wmode;
  logic             tick;
  logic             is_pwm;
  logic             is_fast;
  logic             top_is_a;
  logic [7:0]       top_val;
  logic             at_top;
  logic             at_max;
  logic             at_bot;
  logic             ovf_set;
  logic             ext_rise;
  logic             ext_fall;
  logic             pre_tap;

  function automatic logic tap_hit(input logic [PRE_W-1:0] p,
                                   input int              bits);
    logic [PRE_W-1:0] m;
    m = PRE_W'((1 << bits) - 1);
    tap_hit = ((p & m) == m);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // mode and top decode
  assign wmode    = {waveform_mode_bit2, waveform_mode_bit1,
                     waveform_mode_bit0};                        // R10
  assign is_fast  = (wmode == WM_FAST_MAX) || (wmode == WM_FAST_A); // R24
  // any mode with a low bit set is a pwm flavour
  assign is_pwm   = wmode[0];                                    // R15
  assign top_is_a = (wmode == WM_CLEAR) || (wmode == WM_FAST_A); // R3
  assign top_val  = top_is_a ? ca.active : TCC_MAX;              // R3
  assign at_top   = (cnt_r == top_val);
  assign at_max   = (cnt_r == TCC_MAX);                          // R2
  assign at_bot   = (cnt_r == TCC_BOTTOM);                       // R1

  ////////////////////////////////////////////////////////////////////////
  // tick source; ext_sync_r[0] feeds only ext_sync_r[1]
  assign ext_rise = ext_sync_r[1] & ~ext_sync_r[2];
  assign ext_fall = ~ext_sync_r[1] & ext_sync_r[2];

  always_comb begin
    unique case (clock_select_field)                             // R6 R23
      CS_STOP:     pre_tap = 1'b0;                               // R7
      CS_DIV1:     pre_tap = 1'b1;
      CS_DIV8:     pre_tap = tap_hit(pre_r, 3);
      CS_DIV64:    pre_tap = tap_hit(pre_r, 6);
      CS_DIV256:   pre_tap = tap_hit(pre_r, 8);
      CS_DIV1024:  pre_tap = tap_hit(pre_r, 10);
      CS_EXT_FALL: pre_tap = ext_fall;
      CS_EXT_RISE: pre_tap = ext_rise;
    endcase
  end
  assign tick = pre_tap;

  ////////////////////////////////////////////////////////////////////////
  // counter next value
  always_comb begin
    cnt_nxt = cnt_r;
    ovf_set = 1'b0;
    if (counter_wr) begin
      cnt_nxt = counter_wdata;                                   // R9
    end else if (tick) begin
      if (wmode == WM_CLEAR && at_top) begin
        cnt_nxt = TCC_BOTTOM;                                    // R8
        ovf_set = at_max;                                        // R11
      end else if (is_fast && at_top) begin
        cnt_nxt = TCC_BOTTOM;                                    // R8
        ovf_set = 1'b1;                                          // R11
      end else if (is_pwm && !is_fast) begin
        // dual-slope modes are not built; modes 1 and 5 only count down
        cnt_nxt = 8'(cnt_r - 8'h01);                             // R8
        ovf_set = at_bot;
      end else begin
        cnt_nxt = 8'(cnt_r + 8'h01);                             // R8
        ovf_set = at_max;                                        // R11
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // channel wiring
  assign ca.count = cnt_r;
  assign ca.tick = tick;
  assign ca.blocked = blk_r;
  assign ca.pwm = is_pwm;
  assign ca.at_top = at_top;
  assign ca.at_bottom = at_bot;
  assign ca.fast = is_fast;
  assign cb.count = cnt_r;
  assign cb.tick = tick;
  assign cb.blocked = blk_r;
  assign cb.pwm = is_pwm;
  assign cb.at_top = at_top;
  assign cb.at_bottom = at_bot;
  assign cb.fast = is_fast;

  tcc_compare_ch u_cha (
    .clock        (clock),
    .srst         (srst),
    .cb           (ca.chn),
    .cmp_wr       (compare_a_wr),
    .cmp_wdata    (compare_a_wdata),
    .action       (output_action_a),
    .force_strobe (force_compare_strobe_a),
    .cmp_rdata    (cmpa_rd),
    .wave_r       (wave_a),
    .flag_set     (set_a)
  );

  tcc_compare_ch u_chb (
    .clock        (clock),
    .srst         (srst),
    .cb           (cb.chn),
    .cmp_wr       (compare_b_wr),
    .cmp_wdata    (compare_b_wdata),
    .action       (output_action_b),
    .force_strobe (force_compare_strobe_b),
    .cmp_rdata    (cmpb_rd),
    .wave_r       (wave_b),
    .flag_set     (set_b)
  );

  ////////////////////////////////////////////////////////////////////////
  // flags: hardware set wins over software or service clear
  always_comb begin
    flag_nxt = flag_r;
    if (flag_wr) flag_nxt = flag_nxt & ~flag_wdata;              // R14
    flag_nxt = flag_nxt & ~irq_ack;                              // R14
    if (ovf_set) flag_nxt[FLAG_OVF] = 1'b1;                      // R11
    if (set_a) flag_nxt[FLAG_CMPA] = 1'b1;                       // R13
    if (set_b) flag_nxt[FLAG_CMPB] = 1'b1;                       // R13
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock) begin
    if (srst) begin
      cnt_r      <= TCC_RST_BYTE;                                // R26
      pre_r      <= '0;
      ext_sync_r <= '0;
      blk_r      <= 1'b0;
      flag_r     <= '0;                                          // R26
      irq_r      <= '0;
      bottom_r   <= 1'b0;
      cmpa_rd_r  <= TCC_RST_BYTE;
      cmpb_rd_r  <= TCC_RST_BYTE;
    end else begin
      cnt_r      <= cnt_nxt;                                     // R4
      pre_r      <= PRE_W'(pre_r + 1'b1);
      ext_sync_r <= {ext_sync_r[1:0], external_count_input};
      // block lasts until the next tick, even with clock stopped
      blk_r      <= counter_wr | (blk_r & ~tick);                // R19
      flag_r     <= flag_nxt;                                    // R5
      irq_r      <= flag_nxt & timer_irq_mask_reg;               // R5
      bottom_r   <= (cnt_nxt == TCC_BOTTOM);                     // R1
      cmpa_rd_r  <= cmpa_rd;
      cmpb_rd_r  <= cmpb_rd;
    end
  end

  assign counter_value   = cnt_r;
  assign compare_value_a = cmpa_rd_r;
  assign compare_value_b = cmpb_rd_r;
  assign timer_flag_reg  = flag_r;
  assign irq_req         = irq_r;
  assign bottom          = bottom_r;
  assign waveform_out_a  = wave_a;
  assign waveform_out_b  = wave_b;
endmodule

/* File: tcc_timer8_chk.sv */
// Purpose: port-level checks for the 8-bit timer/counter
// Assumes: single clock, srst synchronous active high
// Notes: idle means clock select zero on two edges in a row
////////////////////////////////////////////////////////////////////////
module tcc_timer8_chk (
  input wire logic       clock,
  input wire logic       srst,
  input wire logic [2:0] clock_select_field,
  input wire logic       waveform_mode_bit0,
  input wire logic       counter_wr,
  input wire logic [7:0] counter_wdata,
  input wire logic [1:0] output_action_a,
  input wire logic [1:0] output_action_b,
  input wire logic       force_compare_strobe_a,
  input wire logic       force_compare_strobe_b,
  input wire logic [2:0] timer_irq_mask_reg,
  input wire logic       flag_wr,
  input wire logic [2:0] flag_wdata,
  input wire logic [2:0] irq_ack,
  input wire logic [7:0] counter_value,
  input wire logic [2:0] timer_flag_reg,
  input wire logic [2:0] irq_req,
  input wire logic       bottom,
  input wire logic       waveform_out_a,
  input wire logic       waveform_out_b
);
  import tcc_pkg::*;
  logic stop_r;
  // one edge of slack: a tick already in flight may still land
  wire  idle = (clock_select_field == CS_STOP) && stop_r;
  wire  no_clr = !flag_wr && (irq_ack == 3'h0);
  always_ff @(posedge clock) stop_r <= (clock_select_field == CS_STOP);
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////////////////
  AST_CNT_WRITE: assert property (counter_wr |=>
    counter_value == $past(counter_wdata)) else $error("counter write lost");
  AST_STOP_HOLDS: assert property (idle && !counter_wr |=>
    $stable(counter_value)) else $error("counter moved while stopped");
  AST_RESET_ZERO: assert property (disable iff (1'b0) srst |=>
    counter_value == 8'h00 && timer_flag_reg == 3'h0 && !waveform_out_a
    && !waveform_out_b) else $error("reset state wrong");
  AST_NOT_BOTTOM: assert property ($stable(counter_value) &&
    counter_value != TCC_BOTTOM |-> !bottom) else $error("bottom wrong");
  AST_IRQ_MASK: assert property ($stable(timer_irq_mask_reg) &&
    $stable(timer_flag_reg) |-> irq_req == (timer_flag_reg &
    timer_irq_mask_reg)) else $error("irq request not flag and mask");
  AST_FLAG_STICKY: assert property (no_clr |=> (timer_flag_reg &
    $past(timer_flag_reg)) == $past(timer_flag_reg))
    else $error("flag dropped without clear");
  AST_FLAG_W1C: assert property (idle && flag_wr |=>
    (timer_flag_reg & $past(flag_wdata)) == 3'h0) else $error("w1c failed");
  AST_ACK_CLR: assert property (idle && irq_ack != 3'h0 |=>
    (timer_flag_reg & $past(irq_ack)) == 3'h0) else $error("ack failed");
  AST_FORCE_SET_A: assert property (force_compare_strobe_a &&
    !waveform_mode_bit0 && output_action_a == ACT_SET |=> waveform_out_a)
    else $error("force set missed");
  AST_FORCE_CLR_B: assert property (force_compare_strobe_b &&
    !waveform_mode_bit0 && output_action_b == ACT_CLEAR |=> !waveform_out_b)
    else $error("force clear missed");
  AST_FORCE_NO_FLAG: assert property (idle && no_clr &&
    (force_compare_strobe_a || force_compare_strobe_b) |=>
    $stable(timer_flag_reg)) else $error("force touched flags");
  cover property (timer_flag_reg[FLAG_OVF] && irq_req[FLAG_OVF]);
  cover property (idle && counter_wr);
  cover property ($rose(waveform_out_a));
endmodule
bind tcc_timer8 tcc_timer8_chk tcc_timer8_chk_inst (.*);

/* File: tcc_timer8_tb_top.sv */
// Purpose: directed bench for the 8-bit timer/counter
// Assumes: inputs driven 1 ns after the rising edge
// Notes: prescaler figures allow for a free running divider phase
////////////////////////////////////////////////////////////////////////
module tcc_timer8_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import tcc_pkg::*;
  logic clock, srst, external_count_input, counter_wr, compare_a_wr;
  logic compare_b_wr, force_compare_strobe_a, force_compare_strobe_b;
  logic flag_wr, waveform_mode_bit0, waveform_mode_bit1, waveform_mode_bit2;
  logic bottom, waveform_out_a, waveform_out_b;
  logic [2:0] clock_select_field, timer_irq_mask_reg, flag_wdata, irq_ack;
  logic [2:0] timer_flag_reg, irq_req;
  logic [7:0] counter_wdata, compare_a_wdata, compare_b_wdata, v, mx;
  logic [7:0] counter_value, compare_value_a, compare_value_b;
  logic [1:0] output_action_a, output_action_b;
  int         error_cnt, samples_checked, cyc;
  tcc_timer8 tcc_timer8_inst (.*);
  ////////////////////////////////////////////////////////////////////////
  task automatic step(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr_cnt(logic [7:0] d);
    counter_wdata = d;
    counter_wr = 1;
    step(1);
    counter_wr = 0;
    step(1);
  endtask
  task automatic wr_cmp(bit b, logic [7:0] d);
    compare_a_wdata = d;
    compare_b_wdata = d;
    if (b) compare_b_wr = 1;
    else compare_a_wr = 1;
    step(1);
    {compare_a_wr, compare_b_wr} = 2'h0;
    step(1);
  endtask
  task automatic clr(logic [2:0] f, bit ack);
    flag_wdata = f;
    if (ack) irq_ack = f;
    else flag_wr = 1;
    step(1);
    irq_ack = 3'h0;
    flag_wr = 0;
    step(1);
  endtask
  task automatic frc(logic [1:0] act);
    {output_action_a, output_action_b} = {act, act};
    {force_compare_strobe_a, force_compare_strobe_b} = 2'h3;
    step(1);
    {force_compare_strobe_a, force_compare_strobe_b} = 2'h0;
    step(1);
  endtask
  task automatic mode(logic [2:0] m);
    {waveform_mode_bit2, waveform_mode_bit1, waveform_mode_bit0} = m;
  endtask
  task automatic wait_cnt(logic [7:0] c);
    for (int k = 0; k < 3000 && counter_value !== c; k++) step(1);
  endtask
  task automatic report_and_stop();
    if (error_cnt == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 0;
    forever #5 clock = ~clock;
  end
  // hang guard, well above the longest prescaler wait
  always @(posedge clock) begin
    cyc++;
    if (cyc > 40000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  initial begin
    {srst, external_count_input, counter_wr, compare_a_wr} = 4'h8;
    {compare_b_wr, force_compare_strobe_a, force_compare_strobe_b} = 3'h0;
    {flag_wr, waveform_mode_bit0, waveform_mode_bit1, waveform_mode_bit2} =
      4'h0;
    {clock_select_field, timer_irq_mask_reg, flag_wdata, irq_ack} = 12'h0;
    {counter_wdata, compare_a_wdata, compare_b_wdata} = 24'h0;
    {output_action_a, output_action_b} = 4'h0;
    step(5);
    srst = 0;
    chk("reset", {counter_value[4:0], timer_flag_reg}, 8'h00);
    chk("reset_wave", 8'({waveform_out_a, waveform_out_b}), 8'h00);
    timer_irq_mask_reg = 3'h7;
    wr_cmp(0, 8'h02);
    chk("cmp_a", compare_value_a, 8'h02);
    clock_select_field = CS_DIV1;
    for (int k = 0; k < 300 && timer_flag_reg[1] !== 1'b1; k++) step(1);
    chk("match_cnt", counter_value, 8'h03);
    chk("irq_a", 8'(irq_req[FLAG_CMPA]), 8'h01);
    timer_irq_mask_reg = 3'h6;
    for (int k = 0; k < 300 && timer_flag_reg[0] !== 1'b1; k++) step(1);
    chk("ovf_cnt", counter_value, TCC_BOTTOM);
    chk("ovf_masked", 8'(irq_req[FLAG_OVF]), 8'h00);
    chk("bottom", 8'(bottom), 8'h01);
    clock_select_field = CS_STOP;
    clr(3'h1, 0);
    chk("w1c", 8'(timer_flag_reg[0]), 8'h00);
    clr(3'h2, 1);
    chk("ack", 8'(timer_flag_reg[1]), 8'h00);
    v = counter_value;
    step(10);
    chk("stopped", counter_value, v);
    wr_cnt(8'hc3);
    chk("cnt_wr", counter_value, 8'hc3);
    // a counter write equal to compare must swallow the first match
    wr_cmp(0, 8'h05);
    wr_cnt(8'h05);
    clock_select_field = CS_DIV1;
    step(6);
    chk("blocked", 8'(timer_flag_reg[1]), 8'h00);
    clock_select_field = CS_STOP;
    wr_cnt(8'h03);
    clock_select_field = CS_DIV1;
    step(8);
    chk("unblocked", 8'(timer_flag_reg[1]), 8'h01);
    clock_select_field = CS_STOP;
    wr_cmp(0, 8'h04);
    wr_cnt(8'h00);
    mode(WM_CLEAR);
    clock_select_field = CS_DIV1;
    mx = 0;
    repeat (30) begin
      step(1);
      if (counter_value > mx) mx = counter_value;
    end
    chk("ctc_top", mx, 8'h04);
    clock_select_field = CS_STOP;
    mode(WM_NORMAL);
    step(2);
    clr(3'h7, 0);
    frc(ACT_SET);
    chk("frc_set", 8'({waveform_out_a, waveform_out_b}), 8'h03);
    frc(ACT_TOGGLE);
    chk("frc_tgl", 8'({waveform_out_a, waveform_out_b}), 8'h00);
    frc(ACT_TOGGLE);
    chk("frc_tgl2", 8'({waveform_out_a, waveform_out_b}), 8'h03);
    chk("frc_flags", 8'(timer_flag_reg), 8'h00);
    mode(WM_FAST_MAX);
    frc(ACT_CLEAR);
    chk("keep_mode", 8'({waveform_out_a, waveform_out_b}), 8'h03);
    mode(WM_NORMAL);
    frc(ACT_CLEAR);
    chk("frc_clr", 8'({waveform_out_a, waveform_out_b}), 8'h00);
    frc(ACT_NONE);
    wr_cmp(1, 8'h80);
    mode(WM_FAST_MAX);
    wr_cmp(1, 8'h20);
    chk("cmp_b_buf", compare_value_b, 8'h20);
    wr_cnt(8'h10);
    clr(3'h7, 0);
    clock_select_field = CS_DIV1;
    wait_cnt(8'h28);
    chk("buf_hold", 8'(timer_flag_reg[2]), 8'h00);
    wait_cnt(8'h90);
    chk("old_active", 8'(timer_flag_reg[2]), 8'h01);
    clr(3'h4, 0);
    wait_cnt(8'h28);
    chk("buf_load", 8'(timer_flag_reg[2]), 8'h01);
    clock_select_field = CS_STOP;
    mode(WM_NORMAL);
    for (int d = 0; d < 4; d++) begin
      v = counter_value;
      clock_select_field = CS_DIV8 + 3'(d);
      step(4 * (8 << (d == 0 ? 0 : 2 * d + 1)));
      mx = counter_value - v;
      chk("prescale", 8'(mx inside {3, 4}), 8'h01);
      clock_select_field = CS_STOP;
      step(2);
    end
    for (int e = 0; e < 2; e++) begin
      v = counter_value;
      clock_select_field = e ? CS_EXT_FALL : CS_EXT_RISE;
      repeat (3) begin
        external_count_input = 1;
        step(3);
        external_count_input = 0;
        step(3);
      end
      step(5);
      chk("ext_edges", counter_value - v, 8'h03);
      clock_select_field = CS_STOP;
      step(2);
    end
    report_and_stop();
  end
endmodule
